// File: hw/ipi_core.v
// Purpose: Interrupt acceptance against the pipeline, flag/enable/pointer registers
// Assumes: Pipeline reports the packet entering the first execute stage each CPU cycle
// Notes: cpuStall stretches the CPU cycle; all interrupt steps except pin sampling and flag setting wait with it
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "ipi_map.vh"

// Summary of operation
// - Defer nonreset interrupts while any of five prior packets has branch or delay slot.
// - Memory stalls stretch CPU cycles, postponing every interrupt step but pin sampling and flag setting equally.
// - Annulled later NOP/idle cycle saves the next packet address as return.
// - Packets past first execute stage finish; later ones annulled and refetched.
// - Non-maskable interrupt may preempt any maskable service routine without software.
// - While non-maskable interrupt is serviced, no interrupt of either class accepted.
// - Table pointer read gives highest pending packet address with number field.
// - Flags and enables readable; writing shifted one to clear register clears flag.
// - Maskable return pointer is software writable as full 32-bit address.
// - Clearing global enable by software write blocks maskable interrupts at once.
// - Predication accepts exactly A1, A2, B0, B1, B2 as condition sources.
// - Immediate branch displacement is a signed 21-bit field; farther needs register.
// - Acceptance ignores serial or parallel fetch encoding; only execute packets matter.
// - Taking a maskable interrupt copies global enable to previous, then clears it.
// - Clear-register one clears flag unless detection sets it same cycle; set wins.
module ipi_core
(
   input wire mclk,
   input wire rst_b,
   input wire ce,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   output reg [1:0] s_axi_bresp,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   input wire [7:0] s_axi_araddr,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   input wire cpuStall,
   input wire exBranch,
   input wire exNopCont,
   input wire [31:0] exAddr,
   input wire [31:0] nextAddr,
   input wire nmiReturn,
   input wire nmiPin,
   input wire [15:4] intPin,
   input wire [2:0] predCode,
   input wire [4:0] condNonZero,
   input wire [31:0] branchPc,
   input wire [20:0] branchDisp,
   output reg intTake,
   output wire annulLater,
   output reg [31:0] vectorAddr,
   output reg iack,
   output reg [4:0] inum,
   output reg predTrue,
   output reg [31:0] branchTarget,
   output wire irq
);

   localparam ST_IDLE = 1'b0;
   localparam ST_PROC = 1'b1;

   reg [15:0] syncA_r;
   reg [15:0] syncB_r;
   reg [15:0] lastLvl_r;
   reg [15:0] flags_r;
   reg [15:0] enable_r;
   reg [1:0] csw_r;
   reg [31:0] mrp_r;
   reg [31:0] nmrp_r;
   reg [21:0] stpBase_r;
   reg [4:0] hist_r;
   reg state_r;
   reg [2:0] procCnt_r;
   reg clrPend_r;
   reg [4:0] clrNum_r;
   reg awHeld_r;
   reg [7:0] awAddr_r;
   reg wHeld_r;
   reg [31:0] wData_r;
   reg [3:0] wStrb_r;

   wire [15:0] pinsNow;
   wire [15:0] riseEv;
   wire cpuStep;
   wire doWrite;
   wire [7:0] wrAddr;
   wire [31:0] wrData;
   wire [31:0] byteMask;
   wire cswWrite;
   wire genEff;
   wire [15:0] pendEn;
   wire deferBranch;
   wire nmiOk;
   wire takeNow;
   reg [4:0] hpNum;
   reg hpAny;
   reg [15:0] clrBits;
   reg [15:0] flagsNxt;
   reg [31:0] rdWord;
   reg rdHit;
   reg wrHit;
   integer i;

   // Bit 0 is reset, bits 2 and 3 are reserved and never flag here
   assign pinsNow = {intPin, 2'b00, nmiPin, 1'b0};
   assign riseEv = syncB_r & ~lastLvl_r;

   // A stalled CPU cycle freezes the acceptance pipeline view
   assign cpuStep = ce & ~cpuStall;

   assign s_axi_awready = ~awHeld_r & ~s_axi_bvalid;
   assign s_axi_wready = ~wHeld_r & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign doWrite = ce & awHeld_r & wHeld_r & ~s_axi_bvalid;
   assign wrAddr = awAddr_r;
   assign wrData = wData_r;
   assign byteMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
   assign cswWrite = doWrite & (wrAddr == `IPI_OFF_CSW) & wStrb_r[0];

   // A write clearing the enable bit blocks the same cycle
   assign genEff = csw_r[`IPI_BIT_GEN] & ~(cswWrite & ~wrData[`IPI_BIT_GEN]);

   assign pendEn = flags_r & enable_r;
   assign irq = |pendEn;

   // Any of the five packets ahead, or the one entering now
   assign deferBranch = (|hist_r) | exBranch;

   // Non-maskable path needs no global enable, so it preempts maskable ISRs
   assign nmiOk = enable_r[`IPI_BIT_NMI];
   assign takeNow = cpuStep & (state_r == ST_IDLE) & hpAny & ~deferBranch & nmiOk
                    & ((hpNum == 5'd`IPI_BIT_NMI) | genEff);

   // Lowest number is highest priority
   always @*
   begin
      hpAny = 1'b0;
      hpNum = 5'h00;
      for (i = `IPI_LAST_MASKABLE; i >= `IPI_BIT_NMI; i = i - 1)
      begin
         if (pendEn[i])
         begin
            hpAny = 1'b1;
            hpNum = i[4:0];
         end
      end
   end

   // Detection set wins over any clear in the same cycle
   always @*
   begin
      clrBits = 16'h0000;
      if (doWrite && wrAddr == `IPI_OFF_CLEAR)
      begin
         clrBits = wrData[15:0] & byteMask[15:0];
      end
      if (clrPend_r && cpuStep)
      begin
         clrBits[clrNum_r[3:0]] = 1'b1;
      end
      flagsNxt = (flags_r & ~clrBits) | riseEv;
      flagsNxt[0] = 1'b0;
   end

   always @*
   begin
      rdHit = 1'b1;
      rdWord = 32'h0000_0000;
      case (s_axi_araddr)
         `IPI_OFF_FLAGS: rdWord = {16'h0000, flags_r};
         `IPI_OFF_CLEAR: rdWord = 32'h0000_0000;
         `IPI_OFF_ENABLE: rdWord = {16'h0000, enable_r};
         `IPI_OFF_CSW: rdWord = {30'h0, csw_r};
         `IPI_OFF_MRP: rdWord = mrp_r;
         `IPI_OFF_NMRP: rdWord = nmrp_r;
         // Service packet address carries the pending number field
         `IPI_OFF_STP: rdWord = {stpBase_r, hpNum, 5'h00};
         default: rdHit = 1'b0;
      endcase
   end

   always @*
   begin
      case (wrAddr)
         `IPI_OFF_CLEAR, `IPI_OFF_ENABLE, `IPI_OFF_CSW,
         `IPI_OFF_MRP, `IPI_OFF_NMRP, `IPI_OFF_STP, `IPI_OFF_FLAGS: wrHit = 1'b1;
         default: wrHit = 1'b0;
      endcase
   end

   // Pin levels cross into mclk through two flops before edge detection
   always @(posedge mclk)
   begin
      if (!rst_b)
      begin
         syncA_r <= 16'h0000;
         syncB_r <= 16'h0000;
         lastLvl_r <= 16'h0000;
      end
      else if (ce)
      begin
         syncA_r <= pinsNow;
         syncB_r <= syncA_r;
         lastLvl_r <= syncB_r;
      end
   end

   // AXI4-Lite channels
   always @(posedge mclk)
   begin
      if (!rst_b)
      begin
         awHeld_r <= 1'b0;
         awAddr_r <= 8'h00;
         wHeld_r <= 1'b0;
         wData_r <= 32'h0000_0000;
         wStrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `IPI_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `IPI_RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld_r <= 1'b1;
            awAddr_r <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         if (doWrite)
         begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrHit ? `IPI_RESP_OKAY : `IPI_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdWord;
            s_axi_rresp <= rdHit ? `IPI_RESP_OKAY : `IPI_RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Registers, flags and acceptance sequence
   always @(posedge mclk)
   begin
      if (!rst_b)
      begin
         flags_r <= 16'h0000;
         enable_r <= `IPI_RST_ENABLE;
         csw_r <= `IPI_RST_CSW;
         mrp_r <= `IPI_RST_PTR;
         nmrp_r <= `IPI_RST_PTR;
         stpBase_r <= `IPI_RST_BASE;
         hist_r <= 5'h00;
         state_r <= ST_IDLE;
         procCnt_r <= 3'h0;
         clrPend_r <= 1'b0;
         clrNum_r <= 5'h00;
         intTake <= 1'b0;
         iack <= 1'b0;
         inum <= 5'h00;
         vectorAddr <= 32'h0000_0000;
      end
      else if (ce)
      begin
         flags_r <= flagsNxt;
         intTake <= 1'b0;
         if (doWrite)
         begin
            case (wrAddr)
               `IPI_OFF_ENABLE: enable_r <= ((enable_r & ~byteMask[15:0])
                                             | (wrData[15:0] & byteMask[15:0])) | 16'h0001;
               `IPI_OFF_CSW: if (wStrb_r[0]) csw_r <= wrData[1:0];
               `IPI_OFF_MRP: mrp_r <= (mrp_r & ~byteMask) | (wrData & byteMask);
               `IPI_OFF_NMRP: nmrp_r <= (nmrp_r & ~byteMask) | (wrData & byteMask);
               `IPI_OFF_STP: stpBase_r <= (stpBase_r & ~byteMask[31:10])
                                          | (wrData[31:10] & byteMask[31:10]);
               default: ;
            endcase
         end
         // Software return from the non-maskable routine reopens acceptance
         if (nmiReturn)
         begin
            enable_r[`IPI_BIT_NMI] <= 1'b1;
         end
         if (cpuStep)
         begin
            hist_r <= {hist_r[3:0], exBranch};
            iack <= 1'b0;
            clrPend_r <= 1'b0;
            case (state_r)
               ST_IDLE:
               begin
                  if (takeNow)
                  begin
                     intTake <= 1'b1;
                     iack <= 1'b1;
                     inum <= hpNum;
                     clrPend_r <= 1'b1;
                     clrNum_r <= hpNum;
                     vectorAddr <= {stpBase_r, hpNum, 5'h00};
                     state_r <= ST_PROC;
                     procCnt_r <= `IPI_OVERHEAD;
                     if (hpNum == 5'd`IPI_BIT_NMI)
                     begin
                        // Mask everything until the routine returns
                        enable_r[`IPI_BIT_NMI] <= 1'b0;
                        nmrp_r <= exNopCont ? nextAddr : exAddr;
                     end
                     else
                     begin
                        mrp_r <= exNopCont ? nextAddr : exAddr;
                        csw_r[`IPI_BIT_PREV] <= genEff;
                        csw_r[`IPI_BIT_GEN] <= 1'b0;
                     end
                  end
               end
               ST_PROC:
               begin
                  procCnt_r <= procCnt_r - 3'h1;
                  if (procCnt_r == 3'h1)
                  begin
                     state_r <= ST_IDLE;
                  end
               end
               default: state_r <= ST_IDLE;
            endcase
         end
      end
   end

   // Later packets are annulled while the vector branch drains
   assign annulLater = (state_r == ST_PROC);

   // Condition sources and immediate branch reach
   always @(posedge mclk)
   begin
      if (!rst_b)
      begin
         predTrue <= 1'b0;
         branchTarget <= 32'h0000_0000;
      end
      else if (ce)
      begin
         case (predCode)
            3'h0: predTrue <= 1'b1;
            `IPI_PRED_B0: predTrue <= condNonZero[0];
            `IPI_PRED_B1: predTrue <= condNonZero[1];
            `IPI_PRED_B2: predTrue <= condNonZero[2];
            `IPI_PRED_A1: predTrue <= condNonZero[3];
            `IPI_PRED_A2: predTrue <= condNonZero[4];
            default: predTrue <= 1'b0;
         endcase
         // Word displacement, sign-extended; beyond it needs a register target
         branchTarget <= branchPc + {{(32 - `IPI_DISP_W - 2){branchDisp[20]}}, branchDisp, 2'b00};
      end
   end

endmodule // ipi_core
`default_nettype wire

// File: inc/ipi_map.vh
// Purpose: Offsets, field positions, reset values and counts for ipi_core
// Assumes: Byte addresses on a 32-bit AXI4-Lite slave, one word per register
// Notes: Included by bare name; definitions only
`ifndef IPI_MAP_VH
`define IPI_MAP_VH

`define IPI_ADDR_W 8
`define IPI_OFF_FLAGS 8'h00
`define IPI_OFF_CLEAR 8'h04
`define IPI_OFF_ENABLE 8'h08
`define IPI_OFF_CSW 8'h0C
`define IPI_OFF_MRP 8'h10
`define IPI_OFF_NMRP 8'h14
`define IPI_OFF_STP 8'h18

`define IPI_BIT_GEN 0
`define IPI_BIT_PREV 1
`define IPI_BIT_NMI 1
`define IPI_FIRST_MASKABLE 4
`define IPI_LAST_MASKABLE 15
`define IPI_STP_BASE_LSB 10
`define IPI_STP_NUM_LSB 5

`define IPI_RST_ENABLE 16'h0001
`define IPI_RST_CSW 2'h0
`define IPI_RST_PTR 32'h0000_0000
`define IPI_RST_BASE 22'h00_0000

`define IPI_HIST_DEPTH 5
`define IPI_OVERHEAD 3'h7

`define IPI_RESP_OKAY 2'h0
`define IPI_RESP_SLVERR 2'h2

`define IPI_PRED_B0 3'h1
`define IPI_PRED_B1 3'h2
`define IPI_PRED_B2 3'h3
`define IPI_PRED_A1 3'h4
`define IPI_PRED_A2 3'h5
`define IPI_DISP_W 21

`endif

// File: verif/ipi_src_model.sv
// Purpose: Interrupt sources facing ipi_core
// Assumes: Bit 1 of req is the non-maskable line, bits 15..4 the maskable ones
// Notes: Pins follow req one cycle later, like a registered peripheral output
`timescale 1ns/1ns
`default_nettype none
module ipi_src_model
(
   input wire logic mclk,
   input wire logic [15:0] req,
   output logic nmiPin = 1'b0,
   output logic [15:4] intPin = 12'h000
);
   always @(posedge mclk)
   begin
      nmiPin <= req[1];
      intPin <= req[15:4];
   end
endmodule // ipi_src_model
`default_nettype wire

// File: verif/ipi_core_monitor.sv
// Purpose: Port-level timing checks for ipi_core
// Assumes: ce only drops while no take or annul window is under way
// Notes: Bound to every ipi_core instance
`timescale 1ns/1ns
`default_nettype none
module ipi_core_monitor
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic cpuStall,
   input wire logic exBranch,
   input wire logic nmiReturn,
   input wire logic [2:0] predCode,
   input wire logic [4:0] condNonZero,
   input wire logic [31:0] branchPc,
   input wire logic [20:0] branchDisp,
   input wire logic intTake,
   input wire logic annulLater,
   input wire logic [31:0] vectorAddr,
   input wire logic [4:0] inum,
   input wire logic predTrue,
   input wire logic [31:0] branchTarget,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_arready
);
   logic [2:0] sinceBr;
   logic nmiBusy;
   wire predExp = predCode == 3'h0 || (predCode < 3'h6 && condNonZero[predCode - 3'h1]);
   wire [31:0] tgtExp = branchPc + {{9{branchDisp[20]}}, branchDisp, 2'h0};
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   // CPU cycles since a branch reached the first execute stage; stalls do not count
   always @(posedge mclk)
   begin
      if (!rst_b)
      begin
         sinceBr <= 3'h7;
         nmiBusy <= 1'b0;
      end
      else
      begin
         if (ce && !cpuStall)
            sinceBr <= exBranch ? 3'h0 : (sinceBr == 3'h7 ? sinceBr : sinceBr + 3'h1);
         if (nmiReturn)
            nmiBusy <= 1'b0;
         else if (intTake && inum == 5'h01)
            nmiBusy <= 1'b1;
      end
   end
   a_branch_defer: assert property (intTake |-> sinceBr >= 3'h6)
      else $error("take too close to a branch");
   a_stall_take: assert property (intTake |-> !$past(cpuStall))
      else $error("take during a stall");
   a_annul_start: assert property (intTake |=> annulLater)
      else $error("annul did not follow take");
   a_annul_len: assert property ($fell(annulLater) |-> $past(annulLater, 7))
      else $error("annul window too short");
   a_annul_notake: assert property (annulLater |=> !intTake)
      else $error("take inside annul window");
   a_nmi_excl: assert property (nmiBusy |-> !intTake)
      else $error("take while nmi serviced");
   a_vector_num: assert property (intTake |-> vectorAddr[9:0] == {inum, 5'h00})
      else $error("vector number field wrong");
   a_pred_eval: assert property ($past(rst_b) && $past(ce) |-> predTrue == $past(predExp))
      else $error("predicate wrong");
   a_branch_tgt: assert property ($past(rst_b) |-> branchTarget == $past(tgtExp))
      else $error("branch target wrong");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
      else $error("read data not held");
   a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while answer pending");
endmodule // ipi_core_monitor
bind ipi_core ipi_core_monitor i_mon (.mclk, .rst_b, .ce, .cpuStall, .exBranch, .nmiReturn,
   .predCode, .condNonZero, .branchPc, .branchDisp, .intTake, .annulLater, .vectorAddr, .inum,
   .predTrue, .branchTarget, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_arready);
`default_nettype wire

// File: verif/interrupt_pipeline_interaction_bench.sv
// Purpose: Self-checking bench for ipi_core
// Assumes: pins come from ipi_src_model; ce and wstrb driven per scenario
// Notes: Expected values are fixed constants, LFSR draws and inline expressions in the bench
`timescale 1ns/1ns
`default_nettype none
`include "ipi_map.vh"
module interrupt_pipeline_interaction_bench;
   logic mclk = '0, rst_b = '0, cpuStall = '0, exBranch = '0, exNopCont = '0, nmiReturn = '0;
   logic ce = '1, tkAck;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
   logic s_axi_rready = '0, tk, pe;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, exAddr = '0, nextAddr = '0, branchPc = '0, rdat, tkVec, v, w;
   logic [20:0] branchDisp = '0;
   logic [15:0] req = '0, rnd = 16'hC691;
   logic [4:0] condNonZero = '0, tkNum;
   logic [2:0] predCode = '0;
   logic [1:0] rsp;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire intTake, annulLater, iack, predTrue, irq, nmiPin;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata, vectorAddr, branchTarget;
   wire [15:4] intPin;
   wire [4:0] inum;
   int error_cnt = 0, cmp_count = 0, i;
   always #20 mclk = ~mclk;
   ipi_src_model i_src (.mclk, .req, .nmiPin, .intPin);
   ipi_core i_dut (.mclk, .rst_b, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
      .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
      .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .cpuStall, .exBranch,
      .exNopCont, .exAddr, .nextAddr, .nmiReturn, .nmiPin, .intPin, .predCode, .condNonZero,
      .branchPc, .branchDisp, .intTake, .annulLater, .vectorAddr, .iack, .inum, .predTrue,
      .branchTarget, .irq);
   task end_sim;
      if (error_cnt == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task nx(output logic [31:0] r);
      rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
      r[15:0] = rnd;
      rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
      r[31:16] = rnd;
   endtask
   // Ready is sampled mid-cycle: inputs only move at rising edges
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      logic ta, tw, tr;
      tr = 1'b0;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= wr;
      s_axi_wvalid <= wr;
      s_axi_arvalid <= !wr;
      for (n = 0; n < 40 && !tr; )
      begin
         @(negedge mclk);
         ta = wr ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
         tw = s_axi_wvalid && s_axi_wready;
         tr = wr ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready;
         rdat = s_axi_rdata;
         rsp = wr ? s_axi_bresp : s_axi_rresp;
         @(posedge mclk);
         n++;
         if (ta)
         begin
            s_axi_awvalid <= 1'b0;
            s_axi_arvalid <= 1'b0;
         end
         if (tw)
            s_axi_wvalid <= 1'b0;
         // Late ready so the slave must hold its answer
         if (n == 3)
         begin
            s_axi_bready <= wr;
            s_axi_rready <= !wr;
         end
         if (tr)
         begin
            s_axi_bready <= 1'b0;
            s_axi_rready <= 1'b0;
         end
      end
      if (!tr)
      begin
         error_cnt++;
         $display("ERROR bus answer expected within 40 cycles seen none");
         end_sim;
      end
   endtask
   task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, rdat);
   endtask
   task wt(input int lim);
      int n;
      tk = 1'b0;
      for (n = 0; n < lim && tk !== 1'b1; n++)
      begin
         @(negedge mclk);
         tk = intTake;
         tkNum = inum;
         tkVec = vectorAddr;
         tkAck = iack;
      end
      @(posedge mclk);
   endtask
   // A take that never comes ends the run at once
   task wtk(input int lim);
      wt(lim);
      chk("take", 1, 32'(tk));
      if (tk !== 1'b1)
         end_sim;
   endtask
   task ci(input logic e);
      @(negedge mclk);
      chk("irq", 32'(e), 32'(irq));
      @(posedge mclk);
   endtask
   initial
   begin
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      rc("enable", `IPI_OFF_ENABLE, 32'h0000_0001);
      rc("csw", `IPI_OFF_CSW, 32'h0);
      bus(1'b0, 8'h1C, 32'h0);
      chk("unmapped", 32'(`IPI_RESP_SLVERR), 32'(rsp));
      bus(1'b1, `IPI_OFF_ENABLE, 32'h0000_FFF2);
      rc("enable", `IPI_OFF_ENABLE, 32'h0000_FFF3);
      bus(1'b1, `IPI_OFF_CSW, 32'h1);
      bus(1'b1, `IPI_OFF_STP, 32'hABCD_E400);
      nx(v);
      exAddr <= v;
      exBranch <= 1'b1;
      req <= 16'h0010;
      wt(30);
      chk("take", 0, 32'(tk));
      ci(1'b1);
      exBranch <= 1'b0;
      cpuStall <= 1'b1;
      wt(20);
      chk("take", 0, 32'(tk));
      // Clock enable low freezes the branch history as a stall does
      ce <= 1'b0;
      cpuStall <= 1'b0;
      wt(10);
      chk("take", 0, 32'(tk));
      ce <= 1'b1;
      wtk(10);
      chk("inum", 4, 32'(tkNum));
      chk("iack", 1, 32'(tkAck));
      chk("vector", 32'hABCD_E480, tkVec);
      rc("return", `IPI_OFF_MRP, v);
      rc("csw", `IPI_OFF_CSW, 32'h2);
      rc("flags", `IPI_OFF_FLAGS, 32'h0);
      bus(1'b1, `IPI_OFF_CSW, 32'h1);
      nx(w);
      nextAddr <= w;
      exNopCont <= 1'b1;
      req <= 16'h0020;
      wtk(20);
      chk("inum", 5, 32'(tkNum));
      rc("return", `IPI_OFF_MRP, w);
      exNopCont <= 1'b0;
      exBranch <= 1'b1;
      bus(1'b1, `IPI_OFF_CSW, 32'h1);
      req <= 16'h0040;
      bus(1'b1, `IPI_OFF_CSW, 32'h0);
      chk("bresp", 32'(`IPI_RESP_OKAY), 32'(rsp));
      exBranch <= 1'b0;
      wt(20);
      chk("take", 0, 32'(tk));
      rc("pointer", `IPI_OFF_STP, 32'hABCD_E4C0);
      bus(1'b1, `IPI_OFF_CLEAR, 32'h40);
      ci(1'b0);
      bus(1'b1, `IPI_OFF_ENABLE, 32'h0000_FF72);
      req <= 16'h0080;
      wt(6);
      ci(1'b0);
      rc("flags", `IPI_OFF_FLAGS, 32'h80);
      bus(1'b1, `IPI_OFF_CLEAR, 32'h80);
      bus(1'b1, `IPI_OFF_ENABLE, 32'h0000_FFF2);
      req <= 16'h0002;
      wtk(20);
      chk("inum", 1, 32'(tkNum));
      rc("nmi return", `IPI_OFF_NMRP, v);
      bus(1'b1, `IPI_OFF_CSW, 32'h1);
      req <= 16'h0100;
      wt(40);
      chk("take", 0, 32'(tk));
      nmiReturn <= 1'b1;
      @(posedge mclk);
      nmiReturn <= 1'b0;
      wtk(20);
      chk("inum", 8, 32'(tkNum));
      bus(1'b1, `IPI_OFF_CSW, 32'h1);
      req <= 16'h0A00;
      wtk(20);
      chk("inum", 9, 32'(tkNum));
      bus(1'b1, `IPI_OFF_CLEAR, 32'h800);
      rc("flags", `IPI_OFF_FLAGS, 32'h0);
      nx(w);
      bus(1'b1, `IPI_OFF_MRP, w);
      rc("return", `IPI_OFF_MRP, w);
      // Only the low byte lane may change
      s_axi_wstrb <= 4'h1;
      bus(1'b1, `IPI_OFF_MRP, v);
      s_axi_wstrb <= 4'hF;
      rc("return", `IPI_OFF_MRP, {w[31:8], v[7:0]});
      for (i = 0; i < 24; i++)
      begin
         nx(v);
         nx(w);
         predCode <= v[2:0];
         condNonZero <= v[7:3];
         branchDisp <= v[28:8];
         branchPc <= w;
         pe = v[2:0] == 3'h0 || (v[2:0] < 3'h6 && v[v[2:0] + 3'h2]);
         @(posedge mclk);
         @(negedge mclk);
         chk("pred", 32'(pe), 32'(predTrue));
         chk("target", w + {{9{v[28]}}, v[28:8], 2'h0}, branchTarget);
         @(posedge mclk);
      end
      end_sim;
   end
endmodule // interrupt_pipeline_interaction_bench
`default_nettype wire
